// ==== hdl/host_port_defines.svh ====
// constants for the host bus port
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

`define ADDR_WIDTH        8
`define CHANNELS          4
`define STYLE_ASYNC_SPLIT 2'h0
`define STYLE_ASYNC_DIR   2'h1
`define STYLE_SYNC_SPLIT  2'h2
`define STYLE_SYNC_DIR    2'h3
`define PCLK_MAX_MHZ      54
`define SYS_CLK_MHZ       10
`define ACCESS_CYCLES     3'h2
`define PIN_RESET_VAL     7'h40

`endif

// ==== hdl/host_port_pkg.sv ====
// types for the host bus port
package host_port_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_BUSY = 4'b0010,
    ST_DONE = 4'b0100,
    ST_WAIT = 4'b1000
  } access_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } access_req_t;

endpackage

// ==== hdl/pin_sync.sv ====
// two-flop synchroniser for a vector of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] reset_val_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // reset value is a constant tie at each instance
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      meta_q   <= reset_val_in;
      sync_out <= reset_val_in;
    end else begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/quad_liu_host_bus_port.sv ====
// parallel host port with hardware-mode pin reuse
// Summary of operation
// - strap high or floating selects hardware mode; host mode needs strap held low.
// - undriven strap reads as hardware mode via internal pull-up; the port has none, tb_top supplies it with a tri1 net.
// - split style: low write strobe pulse with select low is a write.
// - direction style: direction high requests read, low requests write, select low.
// - split style: low read strobe pulse with select low is a read.
// - direction style: low data strobe with select low marks the transfer phase.
// - split style: address captured on falling edge of address latch input.
// - direction style: address captured on falling edge of address strobe.
// - accesses ignored unless active-low device select is low.
// - split style: completion output driven high when access finishes.
// - direction style: transfer acknowledge driven low when access finishes.
// - hardware mode: write, read, latch, select pins become channel all-ones enables.
// - hardware mode: completion pin becomes receive squelch input.
// - bus style code: high style bit upper, low style bit lower.
// - codes 00 async split, 01 async direction, 10 sync split, 11 sync direction.
`include "host_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module quad_liu_host_bus_port
  import host_port_pkg::*;
(
  input  wire logic                     clk_sys_in,
  input  wire logic                     reset_in,
  input  wire logic                     control_source_strap_in,
  input  wire logic                     host_bus_style_bit_low_in,
  input  wire logic                     host_bus_style_bit_high_in,
  input  wire logic                     write_or_direction_in,
  input  wire logic                     fetch_or_transfer_strobe_in,
  input  wire logic                     address_capture_input_in,
  input  wire logic                     device_select_n_in,
  input  wire logic [`ADDR_WIDTH-1:0]   address_in,
  input  wire logic                     access_complete_in,
  output logic                          access_complete_out,
  output logic                          access_complete_oe_out,
  output logic                          host_mode_out,
  output logic                          sync_style_out,
  output logic                          access_valid_out,
  output logic                          access_write_out,
  output logic [`ADDR_WIDTH-1:0]        access_addr_out,
  output logic [`CHANNELS-1:0]          send_all_ones_out,
  output logic                          receive_squelch_out
);
  // ==========================================================
  // pin synchronisers
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] pins_s;
  // strap resets to hardware mode, as the pull-up would give; channel pins
  // reset to their pulled-down level so no all-ones burst follows reset
  localparam logic [NSYNC-1:0] PIN_RESET = `PIN_RESET_VAL;
  assign pins_raw = {control_source_strap_in, host_bus_style_bit_high_in, host_bus_style_bit_low_in,
                     device_select_n_in, address_capture_input_in,
                     fetch_or_transfer_strobe_in, write_or_direction_in};

  pin_sync #(.WIDTH(NSYNC)) u_ctl_sync (
    .clk_sys_in   (clk_sys_in),
    .reset_in     (reset_in),
    .reset_val_in (PIN_RESET),
    .pin_in       (pins_raw),
    .sync_out     (pins_s)
  );

  logic [`ADDR_WIDTH-1:0] addr_meta_q;
  logic [`ADDR_WIDTH-1:0] addr_s_q;
  logic                   squelch_meta_q;
  logic                   squelch_s_q;
  // address bits cross one by one; the host holds them still around the latch edge
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      addr_meta_q <= 8'h00;
      addr_s_q    <= 8'h00;
    end else begin
      addr_meta_q <= address_in;
      addr_s_q    <= addr_meta_q;
    end
  end

  // squelch resets to its pulled-down level
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      squelch_meta_q <= 1'b0;
      squelch_s_q    <= 1'b0;
    end else begin
      squelch_meta_q <= access_complete_in;
      squelch_s_q    <= squelch_meta_q;
    end
  end

  // ==========================================================
  // mode and style decode
  wire       wr_dir_s  = pins_s[0];
  wire       fetch_or_transfer_strobe_s   = pins_s[1];
  wire       ale_s     = pins_s[2];
  wire       sel_n_s   = pins_s[3];
  wire [1:0] style     = pins_s[5:4];
  wire       host_mode = ~pins_s[6];
  wire       dir_style = (style == `STYLE_ASYNC_DIR) || (style == `STYLE_SYNC_DIR);
  wire       sync_sty  = (style == `STYLE_SYNC_SPLIT) || (style == `STYLE_SYNC_DIR);
  wire       selected  = host_mode & ~sel_n_s;

  // ==========================================================
  // address capture on strobe falling edge
  logic ale_prev_q;
  logic [`ADDR_WIDTH-1:0] addr_q;
  wire  addr_fall = ale_prev_q & ~ale_s & host_mode;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ale_prev_q <= 1'b0;
      addr_q     <= 8'h00;
    end else begin
      ale_prev_q <= ale_s;
      if (addr_fall) begin
        addr_q <= addr_s_q;
      end
    end
  end

  // ==========================================================
  // access request decode
  wire split_wr   = ~dir_style & ~wr_dir_s;
  wire split_rd   = ~dir_style & ~fetch_or_transfer_strobe_s;
  wire dir_xfer   = dir_style & ~fetch_or_transfer_strobe_s;
  wire dir_write  = ~wr_dir_s;
  // both split strobes low at once is treated as a write
  wire strobe_act = selected & (split_wr | split_rd | dir_xfer);
  wire req_write  = dir_style ? dir_write : split_wr;

  // ==========================================================
  // access state machine
  access_state_t state_q;
  access_state_t state_d;
  logic [2:0]    cnt_q;
  access_req_t   req_q;
  wire           busy_end = (cnt_q == `ACCESS_CYCLES);
  wire           req_take = (state_q == ST_IDLE) && strobe_act;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (strobe_act) state_d = ST_BUSY;
      // select released mid-access: drop it without a valid pulse
      ST_BUSY: if (!selected) state_d = ST_IDLE;
               else if (busy_end) state_d = ST_DONE;
      ST_DONE: state_d = ST_WAIT;
      // one indication per access: wait for select or strobe release
      ST_WAIT: if (!strobe_act) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // cleared outside busy so every access waits the full count
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= (state_q == ST_BUSY) ? cnt_q + 3'h1 : 3'h0;
    end
  end

  // ==========================================================
  // request register
  // kind and address frozen at the strobe; a later latch edge cannot alter them
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      req_q <= '0;
    end else begin
      req_q.valid <= (state_q == ST_BUSY) && (state_d == ST_DONE);
      if (req_take) begin
        req_q.write <= req_write;
        req_q.addr  <= addr_q;
      end
    end
  end

  // ==========================================================
  // completion output and hardware-mode controls
  wire done_ind = (state_q == ST_DONE) || (state_q == ST_WAIT);
  wire done_lvl = done_ind & selected;
  logic done_pin_q;
  logic [`CHANNELS-1:0] all_ones_q;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      done_pin_q <= 1'b0;
    end else begin
      // split: high when done; direction: low when done; idle level otherwise
      done_pin_q <= dir_style ? ~done_lvl : done_lvl;
    end
  end

  // ==========================================================
  // hardware-mode channel controls
  // held low in host mode so bus traffic never reaches the line drivers
  wire [`CHANNELS-1:0] hw_pin_lvl = {sel_n_s, ale_s, fetch_or_transfer_strobe_s, wr_dir_s};
  for (genvar ch = 0; ch < `CHANNELS; ch++) begin : g_all_ones
    always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
        all_ones_q[ch] <= 1'b0;
      end else begin
        all_ones_q[ch] <= host_mode ? 1'b0 : hw_pin_lvl[ch];
      end
    end
  end

  assign access_complete_out    = done_pin_q;
  assign access_complete_oe_out = host_mode;
  assign host_mode_out          = host_mode;
  assign sync_style_out         = sync_sty;
  assign access_valid_out       = req_q.valid;
  assign access_write_out       = req_q.write;
  assign access_addr_out        = req_q.addr;
  assign send_all_ones_out      = all_ones_q;
  assign receive_squelch_out    = ~host_mode & squelch_s_q;
endmodule
`default_nettype wire

// ==== verification/host_port_properties.sv ====
// assertion checker for the host bus port
`timescale 1ns/1ps
`default_nettype none
module host_port_properties (
  input wire logic       clk_sys_in,
  input wire logic       reset_in,
  input wire logic       host_bus_style_bit_low_in,
  input wire logic       write_or_direction_in,
  input wire logic       fetch_or_transfer_strobe_in,
  input wire logic       address_capture_input_in,
  input wire logic       device_select_n_in,
  input wire logic       access_complete_out,
  input wire logic       access_complete_oe_out,
  input wire logic       host_mode_out,
  input wire logic       access_valid_out,
  input wire logic       access_write_out,
  input wire logic [3:0] send_all_ones_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire logic [3:0] hw_pins = {device_select_n_in, address_capture_input_in,
                              fetch_or_transfer_strobe_in, write_or_direction_in};
  wire logic req = host_mode_out && !device_select_n_in && !fetch_or_transfer_strobe_in;
  // ==========================================
  // access steps
  sequence s_start;
    $rose(req);
  endsequence
  sequence s_done;
    ##[3:12] access_valid_out;
  endsequence
  a_hw_quiet_port: assert property (!host_mode_out |-> !access_valid_out && !access_complete_oe_out)
    else $error("access or pin drive in hardware mode");
  a_hw_ones_track: assert property ((!host_mode_out && $stable(hw_pins))[*5] |-> send_all_ones_out == hw_pins)
    else $error("all-ones enables do not follow pins");
  a_valid_single: assert property (access_valid_out |=> !access_valid_out)
    else $error("access pulse longer than one cycle");
  a_idle_sel: assert property (device_select_n_in [*6] |-> !access_valid_out)
    else $error("access without device select");
  a_strobe_serves: assert property (s_start |-> s_done)
    else $error("strobed access never served");
  a_split_ready: assert property (host_mode_out && !host_bus_style_bit_low_in && access_valid_out |=> access_complete_out)
    else $error("ready not raised after access");
  a_dir_ack: assert property (host_mode_out && host_bus_style_bit_low_in && access_valid_out |=> !access_complete_out)
    else $error("acknowledge not lowered after access");
  a_write_kind: assert property (access_valid_out |-> access_write_out == !write_or_direction_in)
    else $error("access direction wrong");
endmodule
bind quad_liu_host_bus_port host_port_properties host_port_properties_i (
  .clk_sys_in, .reset_in, .host_bus_style_bit_low_in, .write_or_direction_in,
  .fetch_or_transfer_strobe_in, .address_capture_input_in, .device_select_n_in,
  .access_complete_out, .access_complete_oe_out, .host_mode_out, .access_valid_out,
  .access_write_out, .send_all_ones_out);
`default_nettype wire

// ==== verification/host_bus_model.sv ====
// host processor bus master model
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic       clk_in,
  input  wire logic       done_in,
  output wire logic       strap_out,
  output logic      [1:0] style_out,
  output logic            wr_out,
  output logic            stb_out,
  output logic            ale_out,
  output logic            sel_n_out,
  output logic      [7:0] addr_out
);
  logic host_q = 1'b0;
  // strap floats for hardware mode, board pull-up does the rest
  assign strap_out = host_q ? 1'b0 : 1'bz;
  initial {style_out, sel_n_out, ale_out, stb_out, wr_out, addr_out} = {2'h0, 4'hb, 8'h00};
  task automatic hw(input logic on, input logic [3:0] v);
    @(negedge clk_in);
    host_q = !on;
    {sel_n_out, ale_out, stb_out, wr_out} = v;
  endtask
  task automatic xfer(input logic [1:0] st, input logic wr, input logic sel, input logic [7:0] a, output logic ok);
    ok = 1'b0;
    @(negedge clk_in);
    // sync styles are timed from clk_in, far below the processor clock limit
    style_out = st;
    addr_out = a;
    ale_out = 1'b1;
    repeat (2) @(negedge clk_in);
    ale_out = 1'b0;
    repeat (3) @(negedge clk_in);
    sel_n_out = !sel;
    wr_out = !wr;
    stb_out = !st[0] && wr;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk_in);
      ok = (done_in === !st[0]);
    end
    @(negedge clk_in);
    {sel_n_out, stb_out, wr_out} = 3'h7;
    // released bus shows the complement of the address, not the last address
    addr_out = ~a;
    repeat (6) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// testbench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic            clk_sys_in = 1'b0;
  logic            reset_in = 1'b1;
  logic            squelch = 1'b0;
  tri1             strap;
  wire logic [1:0] style;
  wire logic       wr, stb, ale, sel_n, pin;
  wire logic [7:0] addr, access_addr_out;
  wire logic       access_complete_out, access_complete_oe_out, host_mode_out, sync_style_out;
  wire logic       access_valid_out, access_write_out, receive_squelch_out;
  wire logic [3:0] send_all_ones_out;
  logic      [7:0] seen_addr;
  logic            seen_wr;
  int              n_valid = 0, err_total = 0, n_tests = 0;
  assign pin = access_complete_oe_out ? access_complete_out : squelch;
  quad_liu_host_bus_port quad_liu_host_bus_port_i (
    .clk_sys_in, .reset_in, .control_source_strap_in(strap),
    .host_bus_style_bit_low_in(style[0]), .host_bus_style_bit_high_in(style[1]),
    .write_or_direction_in(wr), .fetch_or_transfer_strobe_in(stb),
    .address_capture_input_in(ale), .device_select_n_in(sel_n), .address_in(addr),
    .access_complete_in(pin), .access_complete_out, .access_complete_oe_out, .host_mode_out,
    .sync_style_out, .access_valid_out, .access_write_out, .access_addr_out,
    .send_all_ones_out, .receive_squelch_out);
  host_bus_model host_bus_model_i (.clk_in(clk_sys_in), .done_in(pin), .strap_out(strap),
    .style_out(style), .wr_out(wr), .stb_out(stb), .ale_out(ale), .sel_n_out(sel_n), .addr_out(addr));
  initial forever #50 clk_sys_in = ~clk_sys_in;
  always @(negedge clk_sys_in) if (access_valid_out === 1'b1) begin
    n_valid++;
    seen_addr = access_addr_out;
    seen_wr = access_write_out;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_hw;
    for (int v = 0; v < 16; v += 5) begin
      host_bus_model_i.hw(1'b1, v[3:0]);
      squelch = v[0];
      repeat (5) @(negedge clk_sys_in);
      check("all_ones", 8'(v[3:0]), 8'(send_all_ones_out));
      check("squelch", 8'(v[0]), 8'(receive_squelch_out));
      check("mode", 8'h00, 8'({access_complete_oe_out, host_mode_out}));
    end
  endtask
  task automatic t_host;
    logic ok;
    logic [7:0] a;
    int n0;
    host_bus_model_i.hw(1'b0, 4'hb);
    repeat (4) @(negedge clk_sys_in);
    check("host_mode", 8'h03, 8'({access_complete_oe_out, host_mode_out}));
    check("host_ones", 8'h00, 8'(send_all_ones_out));
    check("host_squelch", 8'h00, 8'(receive_squelch_out));
    for (int s = 0; s < 4; s++) begin
      for (int w = 0; w < 2; w++) begin
        n0 = n_valid;
        a = 8'(8'h30 + s * 2 + w);
        host_bus_model_i.xfer(s[1:0], w[0], 1'b1, a, ok);
        check("done", 8'h01, 8'(ok));
        if (ok !== 1'b1) final_report;
        check("count", 8'(n0 + 1), 8'(n_valid));
        check("addr", a, seen_addr);
        check("write", 8'(w[0]), 8'(seen_wr));
        check("sync", 8'(s[1]), 8'(sync_style_out));
        check("release", 8'(s[0]), 8'(pin));
      end
    end
  endtask
  task automatic t_nosel;
    logic ok;
    int n0;
    n0 = n_valid;
    host_bus_model_i.xfer(2'h1, 1'b0, 1'b0, 8'h55, ok);
    check("ignored", 8'(n0), 8'(n_valid));
    check("no_ack", 8'h00, 8'(ok));
  endtask
  initial begin
    repeat (2) @(negedge clk_sys_in);
    reset_in = 1'b0;
    t_hw;
    t_host;
    t_nosel;
    final_report;
  end
endmodule
`default_nettype wire
